// ---- rtl/hbsd_pkg.sv ----
package hbsd_pkg;
    // strap field positions
    localparam int STRAP_W = 8;
    localparam int STRAP_MODE_LSB = 0;
    localparam int STRAP_MODE_W = 4;
    localparam int STRAP_RSVD_BIT = 4;
    localparam int STRAP_CLKDIV_BIT = 5;
    localparam int STRAP_WAITDRV_BIT = 6;
    localparam int STRAP_MEDIA_BIT = 7;
    localparam logic [3:0] MODE_NATIVE_BE = 4'hb;
    localparam logic [7:0] STRAP_RESET = 8'h00;

    // host address: 21 offset bits plus the memory/register select
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int BLT_BIT = 20;
    localparam int MEDIA_BIT = 12;
    localparam int CTRL_HI = 11;
    localparam int CTRL_LO = 9;
    localparam int MEM_HI = 20;
    localparam int MEM_LO = 18;
    localparam logic [2:0] MEM_LIMIT = 3'h5;
    localparam logic [2:0] CTRL_ZERO = 3'h0;

    // register offsets
    localparam logic [8:0] REG_REVISION = 9'h000;
    localparam logic [8:0] REG_DECODE_DISABLE = 9'h001;
    localparam logic [7:0] DECODE_DISABLE_RESET = 8'h01;
    localparam logic [7:0] REVISION_VALUE = 8'h5a;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    localparam int CLKDIV_RATIO = 2;

    typedef enum logic [2:0] {
        HBSD_REG_NONE,
        HBSD_REG_CTRL,
        HBSD_REG_MEDIA,
        HBSD_REG_BLT,
        HBSD_REG_MEM
    } hbsd_region_t;
endpackage : hbsd_pkg

// ---- rtl/hbsd_host_front.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: straps all eight bits on reset release, choosing bus mode and options.
// RULE2: mode bits 1011 select native bus, big endian, active-high acknowledge.
// RULE3: system keeps strap bit four low; it is reserved.
// RULE4: strap bit five high divides the host bus clock by two.
// RULE5: strap bit six high drives acknowledge always, else only during access.
// RULE6: strap bit seven high makes io twelve media power and enables media port.
// RULE7: memory/register select high routes to display buffer, low to registers.
// RULE8: register offsets 0x000 to 0x1ff decode as control registers.
// RULE9: register offsets 0x1000 to 0x1fff decode as media-port registers.
// RULE10: whole second megabyte decodes as block-transfer registers.
// RULE11: display buffer occupies offsets 0x200000 to 0x33ffff.
// RULE12: host decoder gives an aligned 4M window on the upper ten bits.
// RULE13: software writes zero to offset 001h before relying on full decode.
// RULE14: revision code at 000h reads repeatedly with no side effects.
// RULE15: every access ends with an external acknowledge; host waits on it.
// RULE16: host chip-select unit never asserts burst inhibit itself.
// RULE17: host asserts chip select half a clock after address is valid. The host model drives chip select and address in the same step.
// RULE18: host uses a 16-bit port, no parity, no write protect.
// RULE19: host marks the device window non-cacheable when caching.
// RULE20: a collision with display activity delays acknowledge until arbitration ends.
// RULE21: latched straps hold until the next hardware reset.
module hbsd_host_front (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] config_strap,
    input wire logic chip_sel_n,
    input wire logic bus_start_n,
    input wire logic rd_wr_n,
    input wire logic mem_reg_sel,
    input wire logic [hbsd_pkg::ADDR_W-1:0] addr,
    input wire logic [hbsd_pkg::DATA_W-1:0] wdata,
    input wire logic busy_arb,
    input wire logic [hbsd_pkg::DATA_W-1:0] region_rdata,
    output logic [hbsd_pkg::DATA_W-1:0] rdata,
    output logic rdata_oe,
    output logic ack_out,
    output logic ack_oe,
    output logic burst_inhibit_assert,
    output logic clk_en,
    output logic native_mode,
    output logic big_endian,
    output logic media_port_enable,
    output logic media_port_power_out,
    output logic general_io_twelve_is_io,
    output logic sel_ctrl,
    output logic sel_media,
    output logic sel_blt,
    output logic sel_mem,
    output logic access_strobe,
    output logic access_write
);
    // =====================================================
    // strap capture
    // =====================================================
    logic [7:0] strap_s1_q;
    logic [7:0] strap_s2_q;
    logic [7:0] strap_q;
    logic in_reset_q;
    always_ff @(posedge clk) begin
        strap_s1_q <= config_strap;
        strap_s2_q <= strap_s1_q;
    end
    // capture on the first clock after release; later strap changes are ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            in_reset_q <= 1'b1;
            strap_q <= hbsd_pkg::STRAP_RESET;
        end else if (in_reset_q) begin
            in_reset_q <= 1'b0;
            strap_q <= strap_s2_q; // RULE1 RULE21
        end
    end

    wire logic [3:0] mode_bits = strap_q[hbsd_pkg::STRAP_MODE_LSB +: hbsd_pkg::STRAP_MODE_W];
    wire logic div_on = strap_q[hbsd_pkg::STRAP_CLKDIV_BIT];
    wire logic wait_always = strap_q[hbsd_pkg::STRAP_WAITDRV_BIT];
    wire logic media_on = strap_q[hbsd_pkg::STRAP_MEDIA_BIT];
    wire logic native_d = (mode_bits == hbsd_pkg::MODE_NATIVE_BE); // RULE2

    // =====================================================
    // internal clock enable
    // =====================================================
    logic div_q;
    always_ff @(posedge clk) begin
        if (rst || in_reset_q) begin
            div_q <= 1'b0;
        end else if (div_on) begin
            div_q <= ~div_q; // RULE4
        end else begin
            div_q <= 1'b1;
        end
    end
    wire logic tick = div_on ? div_q : 1'b1; // RULE4

    // =====================================================
    // address decode
    // =====================================================
    function automatic hbsd_pkg::hbsd_region_t region_of(
        input logic mr,
        input logic [hbsd_pkg::ADDR_W-1:0] a
    );
        if (mr) begin
            // 1.25M buffer: 0x200000-0x33ffff of window
            if (a[hbsd_pkg::MEM_HI:hbsd_pkg::MEM_LO] < hbsd_pkg::MEM_LIMIT) begin
                region_of = hbsd_pkg::HBSD_REG_MEM; // RULE7 RULE11
            end else begin
                region_of = hbsd_pkg::HBSD_REG_NONE;
            end
        end else if (a[hbsd_pkg::BLT_BIT]) begin
            region_of = hbsd_pkg::HBSD_REG_BLT; // RULE10
        end else if (a[hbsd_pkg::MEDIA_BIT]) begin
            region_of = hbsd_pkg::HBSD_REG_MEDIA; // RULE9
        end else if (a[hbsd_pkg::CTRL_HI:hbsd_pkg::CTRL_LO] == hbsd_pkg::CTRL_ZERO) begin
            region_of = hbsd_pkg::HBSD_REG_CTRL; // RULE8
        end else begin
            region_of = hbsd_pkg::HBSD_REG_NONE;
        end
    endfunction : region_of

    wire hbsd_pkg::hbsd_region_t region = region_of(mem_reg_sel, addr);
    wire logic start = ~chip_sel_n && ~bus_start_n;

    // =====================================================
    // access sequencing
    // =====================================================
    typedef enum logic [1:0] {HBSD_IDLE, HBSD_WAIT, HBSD_ACK} hbsd_state_t;
    hbsd_state_t state_q;
    hbsd_pkg::hbsd_region_t region_q;
    logic [8:0] off_q;
    logic wr_q;
    logic [7:0] wbyte_q;
    logic [7:0] decode_disable_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= HBSD_IDLE;
            region_q <= hbsd_pkg::HBSD_REG_NONE;
            off_q <= '0;
            wr_q <= 1'b0;
            wbyte_q <= hbsd_pkg::DATA_ZERO;
        end else if (tick) begin
            case (state_q)
                HBSD_IDLE: begin
                    if (start && !in_reset_q) begin
                        region_q <= region;
                        off_q <= addr[hbsd_pkg::CTRL_LO-1:0];
                        wr_q <= ~rd_wr_n;
                        wbyte_q <= wdata[7:0];
                        state_q <= HBSD_WAIT;
                    end
                end
                HBSD_WAIT: begin
                    // hold off the acknowledge while display activity owns the resource
                    if (!busy_arb) begin
                        state_q <= HBSD_ACK; // RULE20
                    end
                end
                HBSD_ACK: state_q <= HBSD_IDLE; // RULE15
                default: state_q <= HBSD_IDLE;
            endcase
        end
    end

    wire logic do_access = tick && (state_q == HBSD_WAIT) && !busy_arb;
    wire logic ctrl_hit = region_q == hbsd_pkg::HBSD_REG_CTRL;
    // until software clears the disable register only control space is decoded
    wire logic full_decode = (decode_disable_q == hbsd_pkg::DATA_ZERO);
    wire logic hit_dis = ctrl_hit && off_q == hbsd_pkg::REG_DECODE_DISABLE;
    wire logic hit_rev = ctrl_hit && off_q == hbsd_pkg::REG_REVISION;

    always_ff @(posedge clk) begin
        if (rst) begin
            decode_disable_q <= hbsd_pkg::DECODE_DISABLE_RESET;
        end else if (do_access && wr_q && hit_dis) begin
            decode_disable_q <= wbyte_q; // RULE13
        end
    end

    wire logic [7:0] reg_byte = hit_rev ? hbsd_pkg::REVISION_VALUE // RULE14
                              : hit_dis ? decode_disable_q : hbsd_pkg::DATA_ZERO;
    // a disabled media port answers like empty space, so no strobe reaches it
    wire logic media_gate = (region_q != hbsd_pkg::HBSD_REG_MEDIA) || media_on; // RULE6
    wire logic ext_hit = full_decode && region_q != hbsd_pkg::HBSD_REG_NONE && !ctrl_hit
                         && media_gate;
    wire logic [15:0] rd_d = ext_hit ? region_rdata : {hbsd_pkg::DATA_ZERO, reg_byte};

    // =====================================================
    // outputs
    // =====================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= '0;
            rdata_oe <= 1'b0;
            ack_out <= 1'b0;
            ack_oe <= 1'b0;
            sel_ctrl <= 1'b0;
            sel_media <= 1'b0;
            sel_blt <= 1'b0;
            sel_mem <= 1'b0;
            access_strobe <= 1'b0;
            access_write <= 1'b0;
        end else begin
            if (do_access) begin
                rdata <= rd_d;
            end
            // one host clock only, even at half rate, so the next cycle is not ended early
            ack_out <= do_access; // RULE15 RULE2
            rdata_oe <= do_access && !wr_q;
            // drive acknowledge always, or only while an access is under way
            ack_oe <= wait_always || (state_q != HBSD_IDLE) || start; // RULE5
            access_strobe <= do_access && (ext_hit || ctrl_hit);
            access_write <= wr_q;
            sel_ctrl <= do_access && ctrl_hit;
            sel_media <= do_access && full_decode && region_q == hbsd_pkg::HBSD_REG_MEDIA
                         && media_on; // RULE6
            sel_blt <= do_access && full_decode && region_q == hbsd_pkg::HBSD_REG_BLT;
            sel_mem <= do_access && full_decode && region_q == hbsd_pkg::HBSD_REG_MEM;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_en <= 1'b0;
            native_mode <= 1'b0;
            big_endian <= 1'b0;
            media_port_enable <= 1'b0;
            media_port_power_out <= 1'b0;
            general_io_twelve_is_io <= 1'b1;
            burst_inhibit_assert <= 1'b1;
        end else begin
            clk_en <= tick && !in_reset_q;
            native_mode <= native_d;
            big_endian <= native_d;
            media_port_enable <= media_on; // RULE6
            media_port_power_out <= media_on;
            general_io_twelve_is_io <= ~media_on;
            // no burst support, so the device always inhibits bursts itself
            burst_inhibit_assert <= 1'b1;
        end
    end
endmodule : hbsd_host_front
`default_nettype wire

// ---- tb/hbsd_host_front_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// port checks
module hbsd_host_front_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic ack_out,
    input wire logic ack_oe,
    input wire logic rdata_oe,
    input wire logic burst_inhibit_assert,
    input wire logic native_mode,
    input wire logic big_endian,
    input wire logic media_port_enable,
    input wire logic media_port_power_out,
    input wire logic general_io_twelve_is_io,
    input wire logic sel_ctrl,
    input wire logic sel_media,
    input wire logic sel_blt,
    input wire logic sel_mem
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic [3:0] sel = {sel_ctrl, sel_media, sel_blt, sel_mem};
    property p_bi; burst_inhibit_assert; endproperty
    a_bi: assert property (p_bi) else $error("burst inhibit low");
    property p_mode; native_mode == big_endian; endproperty
    a_mode: assert property (p_mode) else $error("mode split");
    property p_media;
        media_port_enable == media_port_power_out && general_io_twelve_is_io != media_port_enable;
    endproperty
    a_media: assert property (p_media) else $error("media pin mix");
    // capture edge plus output register follow release, so skip three edges
    property p_hold;
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
            |-> $stable({native_mode, media_port_enable});
    endproperty
    a_hold: assert property (p_hold) else $error("strap moved");
    property p_ack1; ack_out |=> !ack_out; endproperty
    a_ack1: assert property (p_ack1) else $error("ack too long");
    property p_sel; $onehot0(sel); endproperty
    a_sel: assert property (p_sel) else $error("two regions");
    property p_selack; |sel |-> ack_out; endproperty
    a_selack: assert property (p_selack) else $error("select without ack");
    property p_oe; ack_out |-> ack_oe; endproperty
    a_oe: assert property (p_oe) else $error("ack not driven");
    property p_rd; rdata_oe |-> ack_out; endproperty
    a_rd: assert property (p_rd) else $error("read data out of cycle");
    c_mem: cover property (ack_out && sel_mem);
    c_blt: cover property (ack_out && sel_blt);
    c_med: cover property (ack_out && sel_media);
endmodule : hbsd_host_front_asserts
bind hbsd_host_front hbsd_host_front_asserts u_chk (.clk(clk), .rst(rst), .ack_out(ack_out),
    .ack_oe(ack_oe), .rdata_oe(rdata_oe), .burst_inhibit_assert(burst_inhibit_assert),
    .native_mode(native_mode), .big_endian(big_endian), .media_port_enable(media_port_enable),
    .media_port_power_out(media_port_power_out), .sel_ctrl(sel_ctrl), .sel_media(sel_media),
    .general_io_twelve_is_io(general_io_twelve_is_io), .sel_blt(sel_blt), .sel_mem(sel_mem));
`default_nettype wire

// ---- tb/hbsd_host_cpu.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// host processor side; burst inhibit is left to the device
// every access goes out on the bus, nothing is held in a cache
module hbsd_host_cpu (
    input wire logic clk,
    output logic chip_sel_n,
    output logic bus_start_n,
    output logic rd_wr_n,
    output logic mem_reg_sel,
    output logic [hbsd_pkg::ADDR_W-1:0] addr,
    output logic [hbsd_pkg::DATA_W-1:0] wdata,
    input wire logic ack_out
);
    initial begin
        chip_sel_n = 1'b1;
        bus_start_n = 1'b1;
        rd_wr_n = 1'b1;
        mem_reg_sel = 1'b0;
        addr = '0;
        wdata = '0;
    end
    task automatic access(input logic w, input logic m, input logic [20:0] x,
        input logic [15:0] d, output logic ok);
        chip_sel_n <= 1'b0;
        bus_start_n <= 1'b0;
        rd_wr_n <= !w;
        mem_reg_sel <= m;
        addr <= x;
        wdata <= d;
        ok = 1'b0;
        // no wait-state count: the cycle ends on acknowledge, or after 60 clocks without one
        for (int n = 0; n < 60 && !ok; n++) begin
            @(posedge clk);
            ok = (ack_out === 1'b1);
        end
        chip_sel_n <= 1'b1;
        bus_start_n <= 1'b1;
        rd_wr_n <= w;
        mem_reg_sel <= !m;
        addr <= ~x;
        wdata <= ~d;
    endtask : access
endmodule : hbsd_host_cpu
`default_nettype wire

// ---- tb/hbsd_host_front_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module hbsd_host_front_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] strap = 8'h00;
    logic busy = 1'b0;
    logic bz = 1'b0;
    logic [3:0] cyc = 4'h0;
    logic [15:0] rrd = 16'h0000;
    logic [31:0] seed = 32'h16;
    wire logic cs_n, bs_n, rw_n, mr, ack, ack_oe, clk_en, nat, be, mpe, mpp, io12;
    wire logic rd_oe, s_c, s_m, s_b, s_d, st, aw, bi;
    wire logic [20:0] a;
    wire logic [15:0] wd, rd;
    wire logic [15:0] sel_w = {12'h000, s_c, s_m, s_b, s_d};
    wire logic [15:0] flag_w = {13'h0, rd_oe, aw, st};
    wire logic [15:0] cfg_w = {9'h0, bi, nat, be, mpe, mpp, io12, ack_oe};
    int bad_count = 0;
    int samples_checked = 0;
    logic [21:0] tab [9] = '{22'h0001ff, 22'h000200, 22'h001000, 22'h001fff, 22'h100000,
        22'h1fffff, 22'h200000, 22'h33ffff, 22'h340000};
    always #2.5 clk = ~clk;
    // busy runs of four cycles stretch the acknowledge
    always @(posedge clk) begin
        cyc <= cyc + 4'h1;
        busy <= bz & cyc[2];
    end
    hbsd_host_front dut (.clk(clk), .rst(rst), .config_strap(strap), .chip_sel_n(cs_n),
        .bus_start_n(bs_n), .rd_wr_n(rw_n), .mem_reg_sel(mr), .addr(a), .wdata(wd),
        .busy_arb(busy), .region_rdata(rrd), .rdata(rd), .rdata_oe(rd_oe), .ack_out(ack),
        .ack_oe(ack_oe), .burst_inhibit_assert(bi), .clk_en(clk_en), .native_mode(nat),
        .big_endian(be), .media_port_enable(mpe), .media_port_power_out(mpp),
        .general_io_twelve_is_io(io12), .sel_ctrl(s_c), .sel_media(s_m), .sel_blt(s_b),
        .sel_mem(s_d), .access_strobe(st), .access_write(aw));
    hbsd_host_cpu h (.clk(clk), .chip_sel_n(cs_n), .bus_start_n(bs_n), .rd_wr_n(rw_n),
        .mem_reg_sel(mr), .addr(a), .wdata(wd), .ack_out(ack));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [3:0] exp_sel(input logic m, input logic [20:0] x, input logic e);
        if (m) return (x[20:18] < hbsd_pkg::MEM_LIMIT) ? 4'h1 : 4'h0;
        if (x[hbsd_pkg::BLT_BIT]) return 4'h2;
        if (x[hbsd_pkg::MEDIA_BIT]) return e ? 4'h4 : 4'h0;
        return (x[11:9] == hbsd_pkg::CTRL_ZERO) ? 4'h8 : 4'h0;
    endfunction : exp_sel
    function automatic logic [15:0] exp_cfg(input logic [7:0] s);
        logic nb;
        nb = (s[3:0] == hbsd_pkg::MODE_NATIVE_BE);
        return {9'h0, 1'b1, nb, nb, s[7], s[7], !s[7], s[6]};
    endfunction : exp_cfg
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic xfer(input logic w, input logic m, input logic [20:0] x,
        input logic [3:0] es, input logic [15:0] er, input logic [1:0] k);
        logic ok;
        h.access(w, m, x, er, ok);
        if (!ok) begin
            bad_count++;
            results();
        end else begin
            if (k[0]) check(sel_w, 16'(es));
            if (k[0]) check(flag_w, {13'h0, !w, w, |es});
            if (k[1]) check(rd, er);
            @(posedge clk);
        end
    endtask : xfer
    task automatic run(input logic [7:0] s);
        logic [21:0] t;
        logic [3:0] e;
        logic [15:0] r;
        int hi;
        bz <= 1'b0;
        strap <= s;
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        strap <= {~s[7:5], 1'b0, ~s[3:0]};
        hi = 0;
        repeat (4) begin
            @(posedge clk);
            hi += int'(clk_en);
        end
        check(16'(hi), s[5] ? 16'h2 : 16'h4);
        check(cfg_w, exp_cfg(s));
        repeat (2) xfer(1'b0, 1'b0, 21'h0, 4'h8, {8'h00, hbsd_pkg::REVISION_VALUE}, 2'h3);
        xfer(1'b0, 1'b0, 21'h000001, 4'h8, {8'h00, hbsd_pkg::DECODE_DISABLE_RESET}, 2'h3);
        rrd <= 16'h3c5a;
        xfer(1'b0, 1'b1, 21'h000000, 4'h0, 16'h0000, 2'h3);
        xfer(1'b1, 1'b0, 21'h000001, 4'h8, 16'h0000, 2'h1);
        xfer(1'b0, 1'b0, 21'h000001, 4'h8, 16'h0000, 2'h3);
        bz <= 1'b1;
        for (int i = 0; i < 19; i++) begin
            seed = xs(seed);
            t = (i < 9) ? tab[i] : seed[21:0];
            e = exp_sel(t[21], t[20:0], s[7]);
            r = (e inside {4'h1, 4'h2, 4'h4}) ? seed[31:16] : 16'h0000;
            if (e == 4'h8 && t[8:0] == hbsd_pkg::REG_REVISION) begin
                r = {8'h00, hbsd_pkg::REVISION_VALUE};
            end
            rrd <= seed[31:16];
            xfer(1'b0, t[21], t[20:0], e, r, 2'h3);
        end
    endtask : run
    initial begin
        run(8'h0b);
        run(8'heb);
        run(8'h63);
        results();
    end
endmodule : hbsd_host_front_test
`default_nettype wire
